// >>> rtl/power_mgr_pkg.sv
// Purpose: shared constants for the always-powered management block
// Assumes: one 250 MHz clock; rc oscillator edges arrive as a synchronous level
// Notes:   no software-reachable registers; controls are plain ports
package power_mgr_pkg;
	localparam int          SLEEP_W       = 16;          // Sleep counter width
	localparam int          DIV_W         = 8;           // Calibration divider width
	localparam logic [7:0]  DIV_RESET     = 8'h0a;       // 10 kHz / 10 = 1 kHz
	localparam int          PRESC_W       = 4;           // Prescaler exponent width
	localparam logic [3:0]  PRESC_RESET   = 4'h0;        // 2^0: one tick per ms
	localparam int          WDOG_W        = 15;          // Watchdog counter width
	localparam logic [14:0] WDOG_TIMEOUT  = 15'h4e20;    // 20000 RC edges, about 2 s
	localparam int          REG_SETTLE_W  = 8;           // Regulator settle counter width
	localparam logic [7:0]  REG_SETTLE    = 8'h20;       // Clocks before core released

	// One-hot power modes
	typedef enum logic [4:0] {
		MODE_ACTIVE = 5'b00001,
		MODE_IDLE   = 5'b00010,
		MODE_DEEP   = 5'b00100,
		MODE_DOWN   = 5'b01000,
		MODE_WAKE   = 5'b10000
	} power_mode_e;

	// Mode requests from firmware
	typedef enum logic [1:0] {
		REQ_ACTIVE = 2'h0,
		REQ_IDLE   = 2'h1,
		REQ_DEEP   = 2'h2,
		REQ_DOWN   = 2'h3
	} mode_req_e;
endpackage

// >>> rtl/rc_timebase.sv
// Purpose: turns the raw RC clock into calibrated and prescaled ticks
// Assumes: rc_clk_i is a synchronous level sampled at 250 MHz
// Notes:   divider value 0 is treated as 1 to avoid a stuck tick
`timescale 1ns/100ps
`default_nettype none
module rc_timebase
	import power_mgr_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               rc_clk_i,
	input  wire logic [DIV_W-1:0]   div_ratio_i,
	input  wire logic [PRESC_W-1:0] presc_exp_i,
	tick_if.source                  ticks
);
	logic                rc_q;        // Last RC level
	logic [DIV_W-1:0]    div_cnt;     // Calibration divider
	logic [15:0]         presc_cnt;   // Power-of-two prescaler
	logic                rc_edge;
	logic                cal_tick;
	logic [DIV_W-1:0]    next_div_cnt;
	logic [15:0]         next_presc_cnt;
	logic                ms_tick;

	////////////////////////////////////////////////////////////////////////
	// Next-state: edge, divider, prescaler
	always_comb begin
		rc_edge        = rc_clk_i & ~rc_q;
		cal_tick       = 1'b0;
		ms_tick        = 1'b0;
		next_div_cnt   = div_cnt;
		next_presc_cnt = presc_cnt;
		if (rc_edge) begin
			// Software-set ratio calibrates to 1 kHz
			if (div_cnt + 8'h01 >= div_ratio_i) begin
				next_div_cnt = '0;
				cal_tick     = 1'b1;
			end else begin
				next_div_cnt = div_cnt + 8'h01;
			end
		end
		if (cal_tick) begin
			// Prescale by 2^N so each output tick is 2^N ms
			if (presc_cnt + 16'h0001 >= (16'h0001 << presc_exp_i)) begin
				next_presc_cnt = '0;
				ms_tick        = 1'b1;
			end else begin
				next_presc_cnt = presc_cnt + 16'h0001;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rc_q      <= 1'b0;
			div_cnt   <= '0;
			presc_cnt <= '0;
		end else begin
			rc_q      <= rc_clk_i;
			div_cnt   <= next_div_cnt;
			presc_cnt <= next_presc_cnt;
		end
	end

	assign ticks.rc_edge = rc_edge;
	assign ticks.ms_tick = ms_tick;
endmodule
`default_nettype wire

// >>> rtl/sleep_watchdog_power_manager.sv
// Purpose: always-powered sleep timer, watchdog and power-mode controller
// Assumes: firmware strobes are one-cycle pulses on clk_i
// Notes:   the watchdog reset is an internal net; no host port reaches it
`timescale 1ns/100ps
`default_nettype none
module sleep_watchdog_power_manager
	import power_mgr_pkg::*;
#(
	parameter int SETTLE = 32                                // Regulator settle clocks
)(
	input  wire logic                              clk_i,
	input  wire logic                              reset_n_i,
	input  wire logic                              rc_clk_i,          // Raw 10 kHz RC level
	input  wire logic [power_mgr_pkg::DIV_W-1:0]   div_ratio_i,       // Firmware calibration
	input  wire logic [power_mgr_pkg::PRESC_W-1:0] presc_exp_i,       // Firmware 2^N exponent
	input  wire logic [power_mgr_pkg::SLEEP_W-1:0] compare_value_i,   // Firmware compare
	input  wire logic                              compare_enable_i,  // Firmware compare enable
	input  wire logic                              compare_clear_i,   // Firmware flag clear
	input  wire logic                              wdog_restart_i,    // Firmware only
	input  wire logic                              wdog_enable_i,     // Firmware only
	input  wire logic                              mode_req_valid_i,  // Firmware mode strobe
	input  wire logic [1:0]                        mode_req_i,        // Requested mode
	input  wire logic                              interrupt_i,       // Any interrupt
	input  wire logic                              ext_wake_i,        // External wake level
	input  wire logic [7:0]                        core_outputs_i,    // Live pin levels
	output logic      [power_mgr_pkg::SLEEP_W-1:0] sleep_count_o,
	output logic                                   compare_flag_o,
	output logic                                   cpu_halt_o,
	output logic                                   core_power_on_o,
	output logic                                   regulator_enable_o,
	output logic                                   regulator_output_o,
	output logic                                   pins_frozen_o,
	output logic      [7:0]                        pad_outputs_o,
	output logic      [4:0]                        power_mode_o,
	output logic                                   chip_reset_n_o     // Internal reset net
);
	import power_mgr_pkg::*;

	tick_if ticks ();                                        // Timebase to manager

	// Timebase
	rc_timebase u_timebase (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.rc_clk_i    (rc_clk_i),
		.div_ratio_i (div_ratio_i),
		.presc_exp_i (presc_exp_i),
		.ticks       (ticks.source)
	);

	////////////////////////////////////////////////////////////////////////
	// Sleep timer state
	logic [SLEEP_W-1:0] sleep_count;                         // Always-powered counter
	logic               compare_flag;                        // Sticky match flag
	logic               match_pulse;                         // One-cycle match
	logic [SLEEP_W-1:0] next_sleep_count;
	logic               next_compare_flag;
	logic               next_match_pulse;

	// Counter, wrap, compare
	always_comb begin
		next_sleep_count  = sleep_count;
		next_match_pulse  = 1'b0;
		next_compare_flag = compare_flag;
		if (ticks.ms_tick) begin
			// Natural wrap 0xffff to 0 keeps counting
			next_sleep_count = sleep_count + 16'h0001;
			next_match_pulse = compare_enable_i && (next_sleep_count == compare_value_i);
		end
		// Set wins over a same-cycle clear
		if (compare_clear_i) begin
			next_compare_flag = 1'b0;
		end
		if (next_match_pulse) begin
			next_compare_flag = 1'b1;
		end
	end

	// Registers only; the sleep timer never sees the chip reset
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sleep_count  <= '0;
			compare_flag <= 1'b0;
			match_pulse  <= 1'b0;
		end else begin
			sleep_count  <= next_sleep_count;
			compare_flag <= next_compare_flag;
			match_pulse  <= next_match_pulse;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog state
	logic [WDOG_W-1:0] wdog_count;                           // RC-edge counter
	logic              wdog_reset_n;                         // Internal reset, low one clock
	logic [WDOG_W-1:0] next_wdog_count;
	logic              next_wdog_reset_n;

	// Counts RC edges; host has no input here at all
	always_comb begin
		next_wdog_count   = wdog_count;
		next_wdog_reset_n = 1'b1;
		if (!wdog_enable_i || wdog_restart_i) begin
			next_wdog_count = '0;
		end else if (ticks.rc_edge) begin
			if (wdog_count + 15'h0001 >= WDOG_TIMEOUT) begin
				next_wdog_count   = '0;
				next_wdog_reset_n = 1'b0;
			end else begin
				next_wdog_count = wdog_count + 15'h0001;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wdog_count   <= '0;
			wdog_reset_n <= 1'b1;
		end else begin
			wdog_count   <= next_wdog_count;
			wdog_reset_n <= next_wdog_reset_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power mode state
	power_mode_e        mode;                                // Current mode
	logic [7:0]         settle_cnt;                          // Regulator settle wait
	logic [7:0]         frozen_pins;                         // Levels held while asleep
	logic               halt;
	logic               core_on;
	logic               reg_en;
	logic               frozen;
	logic [7:0]         pads;
	power_mode_e        next_mode;
	logic [7:0]         next_settle_cnt;
	logic [7:0]         next_frozen_pins;
	logic               next_halt;
	logic               next_core_on;
	logic               next_reg_en;
	logic               next_frozen;
	logic [7:0]         next_pads;

	// Mode transitions and derived controls
	always_comb begin
		next_mode        = mode;
		next_settle_cnt  = settle_cnt;
		next_frozen_pins = frozen_pins;
		unique case (mode)
			MODE_ACTIVE: begin
				if (mode_req_valid_i) begin
					unique case (mode_req_e'(mode_req_i))
						REQ_IDLE: begin
							next_mode = MODE_IDLE;
						end
						REQ_DEEP: begin
							next_mode        = MODE_DEEP;
							next_frozen_pins = core_outputs_i;
						end
						REQ_DOWN: begin
							next_mode        = MODE_DOWN;
							next_frozen_pins = core_outputs_i;
						end
						REQ_ACTIVE: begin
							next_mode = MODE_ACTIVE;
						end
					endcase
				end
			end
			MODE_IDLE: begin
				// Any interrupt resumes execution
				if (interrupt_i) begin
					next_mode = MODE_ACTIVE;
				end
			end
			MODE_DEEP: begin
				// Timer match or external signal
				if (ext_wake_i || match_pulse) begin
					next_mode       = MODE_WAKE;
					next_settle_cnt = REG_SETTLE_W'(SETTLE);   // Per-instance settle span
				end
			end
			MODE_DOWN: begin
				// External signal only
				if (ext_wake_i) begin
					next_mode       = MODE_WAKE;
					next_settle_cnt = REG_SETTLE_W'(SETTLE);   // Per-instance settle span
				end
			end
			MODE_WAKE: begin
				// Regulator on first, core waits for settle
				if (settle_cnt == 8'h00) begin
					next_mode = MODE_ACTIVE;
				end else begin
					next_settle_cnt = settle_cnt - 8'h01;
				end
			end
			default: begin
				next_mode = MODE_ACTIVE;
			end
		endcase
		next_halt    = (next_mode != MODE_ACTIVE);
		next_reg_en  = (next_mode == MODE_ACTIVE) || (next_mode == MODE_IDLE)
			|| (next_mode == MODE_WAKE);
		next_core_on = (next_mode == MODE_ACTIVE) || (next_mode == MODE_IDLE);
		next_frozen  = !next_core_on;
		next_pads    = next_frozen ? next_frozen_pins : core_outputs_i;
	end

	// Registers only
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mode        <= MODE_ACTIVE;
			settle_cnt  <= '0;
			frozen_pins <= '0;
			halt        <= 1'b0;
			core_on     <= 1'b1;
			reg_en      <= 1'b1;
			frozen      <= 1'b0;
			pads        <= '0;
		end else begin
			mode        <= next_mode;
			settle_cnt  <= next_settle_cnt;
			frozen_pins <= next_frozen_pins;
			halt        <= next_halt;
			core_on     <= next_core_on;
			reg_en      <= next_reg_en;
			frozen      <= next_frozen;
			pads        <= next_pads;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	assign sleep_count_o      = sleep_count;
	assign compare_flag_o     = compare_flag;
	assign cpu_halt_o         = halt;
	assign core_power_on_o    = core_on;
	assign regulator_enable_o = reg_en;
	assign regulator_output_o = reg_en;
	assign pins_frozen_o      = frozen;
	assign pad_outputs_o      = pads;
	assign power_mode_o       = mode;
	assign chip_reset_n_o     = wdog_reset_n;
endmodule
`default_nettype wire

// >>> rtl/tick_if.sv
// Purpose: carries the millisecond tick from the timebase to the manager
// Assumes: single clock domain
// Notes:   pulses are one clock wide
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
	logic rc_edge;   // One pulse per raw RC period
	logic ms_tick;   // One pulse per prescaled millisecond
	modport source (output rc_edge, output ms_tick);
	modport sink   (input rc_edge, input ms_tick);
endinterface
`default_nettype wire

// >>> test/power_mgr_properties.sv
// Purpose: concurrent checks on the power manager's top-level ports
// Assumes: one clk_i domain, synchronous active-low reset
// Notes:   bound into every instance of the manager
`timescale 1ns/100ps
`default_nettype none
module power_mgr_properties
	import power_mgr_pkg::*;
#(
	parameter int SETTLE = 32 // Mirrors the manager's parameter
)(
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        interrupt_i,
	input wire logic        ext_wake_i,
	input wire logic        compare_clear_i,
	input wire logic [7:0]  core_outputs_i,
	input wire logic [15:0] sleep_count_o,
	input wire logic        compare_flag_o,
	input wire logic        cpu_halt_o,
	input wire logic        core_power_on_o,
	input wire logic        regulator_enable_o,
	input wire logic        regulator_output_o,
	input wire logic        pins_frozen_o,
	input wire logic [7:0]  pad_outputs_o,
	input wire logic [4:0]  power_mode_o,
	input wire logic        chip_reset_n_o
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Cycles spent in wake so far; counted, as the span is too long to repeat
	logic [8:0] wake_run;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || power_mode_o != MODE_WAKE) begin
			wake_run <= '0;
		end else begin
			wake_run <= wake_run + 9'h001;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_halt_follows_mode: assert property (cpu_halt_o == (power_mode_o != MODE_ACTIVE))
		else $error("halt does not follow mode");
	chk_idle_irq_wake: assert property (power_mode_o == MODE_IDLE && interrupt_i |=> power_mode_o == MODE_ACTIVE)
		else $error("interrupt did not leave idle");
	chk_sleep_reg_off: assert property (power_mode_o inside {MODE_DEEP, MODE_DOWN}
		|-> !regulator_enable_o && !regulator_output_o && !core_power_on_o)
		else $error("regulator or core on while asleep");
	chk_sleep_frozen: assert property (power_mode_o inside {MODE_DEEP, MODE_DOWN, MODE_WAKE} |-> pins_frozen_o)
		else $error("pins not frozen while asleep");
	chk_mode_onehot: assert property ($onehot(power_mode_o))
		else $error("power mode not one-hot");
	chk_flag_sticky: assert property (compare_flag_o && !compare_clear_i |=> compare_flag_o)
		else $error("compare flag dropped without clear");
	chk_wake_length: assert property ($past(power_mode_o) == MODE_WAKE && power_mode_o != MODE_WAKE
		|-> wake_run == 9'(SETTLE + 1))
		else $error("wake span wrong length");
	chk_frozen_pads_hold: assert property (pins_frozen_o && $past(pins_frozen_o) |-> $stable(pad_outputs_o))
		else $error("pads moved while frozen");
	// Reset clears pads, so the cycle after release is excluded
	chk_live_pads: assert property (!pins_frozen_o && !$past(pins_frozen_o) && $past(reset_n_i)
		|-> pad_outputs_o == $past(core_outputs_i))
		else $error("pads not live");
	chk_wake_reg_first: assert property ($rose(core_power_on_o)
		|-> $past(power_mode_o) == MODE_WAKE && $past(regulator_enable_o))
		else $error("core powered before regulator");
	chk_down_ext_only: assert property (power_mode_o == MODE_DOWN && !ext_wake_i && chip_reset_n_o
		|=> power_mode_o == MODE_DOWN)
		else $error("power down left without external wake");
	chk_count_step_one: assert property (!$stable(sleep_count_o)
		|-> sleep_count_o == $past(sleep_count_o) + 16'h0001)
		else $error("sleep count jumped");
	chk_wdog_pulse_one: assert property (!chip_reset_n_o |=> chip_reset_n_o)
		else $error("watchdog reset longer than one clock");
endmodule
bind sleep_watchdog_power_manager power_mgr_properties #(.SETTLE(SETTLE)) props (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .interrupt_i(interrupt_i), .ext_wake_i(ext_wake_i),
	.compare_clear_i(compare_clear_i), .compare_flag_o(compare_flag_o),
	.core_outputs_i(core_outputs_i), .sleep_count_o(sleep_count_o), .cpu_halt_o(cpu_halt_o),
	.core_power_on_o(core_power_on_o), .regulator_enable_o(regulator_enable_o),
	.regulator_output_o(regulator_output_o), .pins_frozen_o(pins_frozen_o),
	.pad_outputs_o(pad_outputs_o), .power_mode_o(power_mode_o), .chip_reset_n_o(chip_reset_n_o)
);
`default_nettype wire

// >>> test/sleep_watchdog_power_manager_tb.sv
// Purpose: self-checking bench for the power manager
// Assumes: bench drives rc_clk_i fast, one rising edge per two clocks
// Notes:   watchdog run dominates the length, about 50k clocks
`timescale 1ns/100ps
`default_nettype none
module sleep_watchdog_power_manager_tb;
	import power_mgr_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        rc_clk_i = 1'b0;
	logic [7:0]  div_ratio_i = 8'h01;
	logic [3:0]  presc_exp_i = 4'h0;
	logic [15:0] compare_value_i = 16'h0000;
	logic        compare_enable_i = 1'b0;
	logic        compare_clear_i = 1'b0;
	logic        wdog_restart_i = 1'b0;
	logic        wdog_enable_i = 1'b0; // Off until its own scenario
	logic        mode_req_valid_i = 1'b0;
	logic [1:0]  mode_req_i = 2'h0;
	logic        interrupt_i = 1'b0;
	logic        ext_wake_i = 1'b0;
	logic [7:0]  core_outputs_i = 8'h00;
	logic [15:0] sleep_count_o;
	logic        compare_flag_o, cpu_halt_o, core_power_on_o, regulator_enable_o;
	logic        regulator_output_o, pins_frozen_o, chip_reset_n_o;
	logic [7:0]  pad_outputs_o, core_prev, cap;
	logic [4:0]  power_mode_o;
	logic [31:0] seed = 32'hdf79;
	logic [15:0] r;
	int          errors = 0, checked = 0, wd_seen = 0, k;

	sleep_watchdog_power_manager uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rc_clk_i(rc_clk_i),
		.div_ratio_i(div_ratio_i), .presc_exp_i(presc_exp_i), .compare_value_i(compare_value_i),
		.compare_enable_i(compare_enable_i), .compare_clear_i(compare_clear_i),
		.wdog_restart_i(wdog_restart_i), .wdog_enable_i(wdog_enable_i),
		.mode_req_valid_i(mode_req_valid_i), .mode_req_i(mode_req_i), .interrupt_i(interrupt_i),
		.ext_wake_i(ext_wake_i), .core_outputs_i(core_outputs_i), .sleep_count_o(sleep_count_o),
		.compare_flag_o(compare_flag_o), .cpu_halt_o(cpu_halt_o), .core_power_on_o(core_power_on_o),
		.regulator_enable_o(regulator_enable_o), .regulator_output_o(regulator_output_o),
		.pins_frozen_o(pins_frozen_o), .pad_outputs_o(pad_outputs_o), .power_mode_o(power_mode_o),
		.chip_reset_n_o(chip_reset_n_o));

	always #2 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Pins wander every clock; core_prev is what the design just sampled
	always @(posedge clk_i) begin
		core_prev <= core_outputs_i;
		core_outputs_i <= 8'(xs());
		if (chip_reset_n_o === 1'b0) wd_seen <= wd_seen + 1;
	end

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
	endtask

	// One rising RC edge per two clocks
	task automatic rc_edges(input int n);
		repeat (n) begin
			rc_clk_i <= 1'b1;
			@(posedge clk_i);
			rc_clk_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask

	// Strobe a mode request; cap holds the pins sampled with it
	task automatic req(input logic [1:0] m);
		mode_req_valid_i <= 1'b1;
		mode_req_i <= m;
		@(posedge clk_i);
		cap = core_outputs_i;
		mode_req_valid_i <= 1'b0;
		@(negedge clk_i);
	endtask

	// Hang guard, well past the expected run of about 51k clocks
	initial begin
		#300_000;
		errors++;
		conclude();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		// Divider ratio 0 first, then random ratio; random prescaler in every pass
		for (int i = 0; i < 3; i++) begin
			r = 16'(xs());
			div_ratio_i <= (i == 0) ? 8'h00 : 8'(r[1:0]) + 8'h01;
			presc_exp_i <= 4'(r[3:2]);
			k = int'(r[5:4]) + 1;
			do_reset();
			rc_edges(k * ((i == 0) ? 1 : int'(r[1:0]) + 1) * (1 << r[3:2]));
			repeat (3) @(negedge clk_i);
			check("sleep_count", 16'(k), sleep_count_o);
		end
		div_ratio_i <= 8'h01;
		presc_exp_i <= 4'h0;
		compare_value_i <= 16'h0003;
		compare_enable_i <= 1'b1;
		do_reset();
		req(REQ_ACTIVE);
		check("mode", 16'(MODE_ACTIVE), 16'(power_mode_o));
		req(REQ_IDLE);
		check("mode", 16'(MODE_IDLE), 16'(power_mode_o));
		check("core_on", 16'h1, 16'(core_power_on_o));
		check("halt", 16'h1, 16'(cpu_halt_o));
		interrupt_i <= 1'b1;
		@(posedge clk_i);
		interrupt_i <= 1'b0;
		@(negedge clk_i);
		check("mode", 16'(MODE_ACTIVE), 16'(power_mode_o));
		// Deep sleep left by compare match
		req(REQ_DEEP);
		check("mode", 16'(MODE_DEEP), 16'(power_mode_o));
		check("reg_out", 16'h0, 16'(regulator_output_o));
		check("pads", 16'(cap), 16'(pad_outputs_o));
		// Clear held high through the matching edge: the set must win
		compare_clear_i <= 1'b1;
		rc_edges(2);
		rc_clk_i <= 1'b1;
		@(posedge clk_i);
		compare_clear_i <= 1'b0;
		rc_clk_i <= 1'b0;
		@(posedge clk_i);
		repeat (4) @(negedge clk_i);
		check("sleep_count", 16'h3, sleep_count_o);
		check("flag", 16'h1, 16'(compare_flag_o));
		check("mode", 16'(MODE_WAKE), 16'(power_mode_o));
		check("reg_en", 16'h1, 16'(regulator_enable_o));
		check("core_on", 16'h0, 16'(core_power_on_o));
		check("pads", 16'(cap), 16'(pad_outputs_o));
		compare_clear_i <= 1'b1;
		@(posedge clk_i);
		compare_clear_i <= 1'b0;
		repeat (40) @(negedge clk_i);
		check("flag", 16'h0, 16'(compare_flag_o));
		check("mode", 16'(MODE_ACTIVE), 16'(power_mode_o));
		check("pads", 16'(core_prev), 16'(pad_outputs_o));
		// Power down ignores the match, only the external line wakes it
		compare_value_i <= 16'h0006;
		req(REQ_DOWN);
		rc_edges(3);
		repeat (4) @(negedge clk_i);
		check("mode", 16'(MODE_DOWN), 16'(power_mode_o));
		check("sleep_count", 16'h6, sleep_count_o);
		check("pads", 16'(cap), 16'(pad_outputs_o));
		ext_wake_i <= 1'b1;
		@(posedge clk_i);
		ext_wake_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		check("mode", 16'(MODE_WAKE), 16'(power_mode_o));
		repeat (40) @(negedge clk_i);
		check("core_on", 16'h1, 16'(core_power_on_o));
		// Restart mid-count, then exactly one timeout
		wdog_enable_i <= 1'b1;
		rc_edges(5000);
		wdog_restart_i <= 1'b1;
		@(posedge clk_i);
		wdog_restart_i <= 1'b0;
		k = wd_seen;
		rc_edges(19999);
		repeat (3) @(negedge clk_i);
		check("wdog_quiet", 16'(k), 16'(wd_seen));
		rc_edges(1);
		repeat (3) @(negedge clk_i);
		check("wdog_fire", 16'(k + 1), 16'(wd_seen));
		conclude();
	end
endmodule
`default_nettype wire
